// [rtl/svc_gear_scaler.sv]
// Electronic gear scaler: numerator over divisor with carried remainder
`default_nettype none

module svc_gear_scaler (
    input wire logic clk,
    input wire logic rst,
    input wire logic inPulse,
    input wire logic [15:0] numer,
    input wire logic [15:0] denom,
    output logic outPulse,
    output logic busy
);

    // ------------------------------------------------------------------
    // Remainder accumulator
    // ------------------------------------------------------------------
    logic [32:0] acc_ff;         // Carried remainder, never dropped
    logic [32:0] nxt_acc;
    logic fire;                  // One output count this cycle
    logic [32:0] addTerm;
    logic [32:0] subTerm;

    // Zero divisor would fire forever, so it blocks output instead
    assign fire = (denom != 16'h0000) && (acc_ff >= {17'h00000, denom});  // R16
    assign addTerm = inPulse ? {17'h00000, numer} : 33'h000000000;
    assign subTerm = fire ? {17'h00000, denom} : 33'h000000000;
    assign nxt_acc = acc_ff + addTerm - subTerm;  // R16
    assign busy = fire;

    // One count out per cycle; a high ratio at full pulse rate backlogs here
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_ff <= 33'h000000000;
            outPulse <= 1'b0;
        end else begin
            acc_ff <= nxt_acc;
            outPulse <= fire;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_scaler_fire_out: assert property (fire |=> outPulse) // R16
        else $error("Scaler count not emitted");
    a_scaler_keep_rem: assert property (!inPulse && !fire |=> $stable(acc_ff)) // R16
        else $error("Scaler remainder lost");

endmodule : svc_gear_scaler

`default_nettype wire

// [rtl/svc_mode_select.sv]
// Servo command-path selection: gear, control mode, direction, overload alarm
//
// Summary of operation
// R1: Dynamic gear only when enable equals one
// R2: Input OFF first term, ON second term
// R3: Controller sends no pulses near gear change
// R4: Analog settings reset to 300,0,0,300
// R5: Limit inputs decode CCW, CW or stop
// R6: Invert swaps nonzero directions only
// R7: Switch disallowed: mode from setting, pin releases
// R8: Switch allowed: pin selects mode, no release
// R9: Base codes 0 position, 1 speed, 6 torque
// R10: Pin ON advances position-speed-torque-position cycle
// R11: Speed source 0 internal, else external analog
// R12: Overload held too long raises alarm, stops
// R13: Overload check active only when B nonzero
// R14: Gear enabled repurposes inhibit pin as selector
// R15: Feedback counts 10000 per revolution
// R16: Scale by numerator, divide, carry remainder
`default_nettype none

module svc_mode_select #(
    parameter int MS_CYCLES = svc_pkg::OVL_TICK_CYCLES  // Cycles per overload timer tick
) (
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins from the motion controller
    input wire logic cmdPulsePin,
    input wire logic gearSelectPin,
    input wire logic ccwLimitPin,
    input wire logic cwLimitPin,
    input wire logic alarmClearPin,
    input wire logic servoOnPin,
    // Same-domain torque estimate
    input wire logic [15:0] motorTorque,
    // Results
    output logic gearPulse,
    output logic [1:0] activeMode,
    output logic [1:0] runDir,
    output logic speedFromAnalog,
    output logic motorEnable,
    output logic overloadAlarm,
    output logic [15:0] analogSpeedGain,
    output logic [15:0] analogZeroOffset,
    output logic [15:0] analogSpeedLpfBw,
    output logic irq
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    localparam int NPIN = 6;
    logic [NPIN-1:0] pinRaw;
    logic [NPIN-1:0] pinMeta_ff;  // First stage, read only by second
    logic [NPIN-1:0] pinSync_ff;  // Safe to use
    logic [NPIN-1:0] pinPrev_ff;  // For edge detection

    assign pinRaw = {servoOnPin, alarmClearPin, cwLimitPin, ccwLimitPin, gearSelectPin, cmdPulsePin};

    // Two flops per pin, then one more for edges
    generate
        for (genvar i = 0; i < NPIN; i++) begin : g_sync
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    pinMeta_ff[i] <= 1'b0;
                    pinSync_ff[i] <= 1'b0;
                    pinPrev_ff[i] <= 1'b0;
                end else begin
                    pinMeta_ff[i] <= pinRaw[i];
                    pinSync_ff[i] <= pinMeta_ff[i];
                    pinPrev_ff[i] <= pinSync_ff[i];
                end
            end
        end
    endgenerate

    wire pulseRise = pinSync_ff[0] & ~pinPrev_ff[0];
    wire gearSel = pinSync_ff[1];
    wire gearEdge = pinSync_ff[1] ^ pinPrev_ff[1];
    wire ccwOn = pinSync_ff[2];
    wire cwOn = pinSync_ff[3];
    wire altSw = pinSync_ff[4];
    wire altRise = pinSync_ff[4] & ~pinPrev_ff[4];
    wire servoOn = pinSync_ff[5];

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [3:0] modeSel_ff;      // control_mode_select
    logic [1:0] speedSrc_ff;     // speed_source_select
    logic switchAllow_ff;        // mode_switch_allow
    logic dynGear_ff;            // dyn_gear_enable
    logic dirInvert_ff;          // analog_dir_invert
    logic inhIgnore_ff;          // inhibit_ignore
    logic [15:0] gearFirst_ff;
    logic [15:0] gearSecond_ff;
    logic [15:0] gearShared_ff;
    logic [15:0] anaGain_ff;
    logic [15:0] anaZero_ff;
    logic [15:0] anaLpf_ff;
    logic [31:0] ovlCfg_ff;      // [15:0] level, [31:16] time in ms
    localparam int IRQ_W_L = svc_pkg::IRQ_W;
    logic [IRQ_W_L-1:0] irqStat_ff;
    logic [IRQ_W_L-1:0] irqMask_ff;

    // Bus decode, zero wait states
    wire wrEn = psel & penable & pwrite;
    wire rdEn = psel & ~pwrite;
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction
    wire mapped = (paddr <= svc_pkg::OFS_COMMAND) && (paddr[1:0] == 2'h0);
    wire wrCfg = wrEn & hit(paddr, svc_pkg::OFS_MODE_CFG);
    wire wrOvl = wrEn & hit(paddr, svc_pkg::OFS_OVL_CFG);
    wire wrStat = wrEn & hit(paddr, svc_pkg::OFS_IRQ_STAT);
    wire wrMask = wrEn & hit(paddr, svc_pkg::OFS_IRQ_MASK);
    wire swRelease = wrEn & hit(paddr, svc_pkg::OFS_COMMAND) & pwdata[svc_pkg::CMD_RELEASE_BIT];

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // Configuration writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            modeSel_ff <= svc_pkg::RST_MODE_SEL;
            speedSrc_ff <= svc_pkg::RST_SPEED_SRC;
            switchAllow_ff <= 1'b0;
            dynGear_ff <= 1'b0;  // R1
            dirInvert_ff <= 1'b0;  // R4
            inhIgnore_ff <= 1'b0;
            ovlCfg_ff <= svc_pkg::RST_OVL_CFG;
            irqMask_ff <= '0;
        end else begin
            if (wrCfg) begin
                modeSel_ff <= pwdata[svc_pkg::CFG_MODE_LSB +: 4];
                speedSrc_ff <= pwdata[svc_pkg::CFG_SRC_LSB +: 2];
                switchAllow_ff <= pwdata[svc_pkg::CFG_SWITCH_BIT];
                dynGear_ff <= pwdata[svc_pkg::CFG_DYNGEAR_BIT];
                dirInvert_ff <= pwdata[svc_pkg::CFG_INVERT_BIT];
                inhIgnore_ff <= pwdata[svc_pkg::CFG_INHIGN_BIT];
            end
            if (wrOvl) begin
                ovlCfg_ff <= pwdata;
            end
            if (wrMask) begin
                irqMask_ff <= pwdata[IRQ_W_L-1:0];
            end
        end
    end

    // Sixteen-bit parameter words share one pattern
    logic [15:0] wordReg_ff [6];
    localparam logic [7:0] WORD_OFS [6] = '{svc_pkg::OFS_GEAR_FIRST, svc_pkg::OFS_GEAR_SECOND,
        svc_pkg::OFS_GEAR_SHARED, svc_pkg::OFS_ANA_GAIN, svc_pkg::OFS_ANA_ZERO, svc_pkg::OFS_ANA_LPF};
    localparam logic [15:0] WORD_RST [6] = '{svc_pkg::RST_GEAR_TERM, svc_pkg::RST_GEAR_TERM,
        svc_pkg::RST_GEAR_TERM, svc_pkg::RST_ANA_GAIN, svc_pkg::RST_ANA_ZERO, svc_pkg::RST_ANA_LPF};
    generate
        for (genvar w = 0; w < 6; w++) begin : g_word
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    wordReg_ff[w] <= WORD_RST[w];  // R4
                end else if (wrEn && hit(paddr, WORD_OFS[w])) begin
                    wordReg_ff[w] <= pwdata[15:0];
                end
            end
        end
    endgenerate
    assign gearFirst_ff = wordReg_ff[0];
    assign gearSecond_ff = wordReg_ff[1];
    assign gearShared_ff = wordReg_ff[2];
    assign anaGain_ff = wordReg_ff[3];
    assign anaZero_ff = wordReg_ff[4];
    assign anaLpf_ff = wordReg_ff[5];
    assign analogSpeedGain = anaGain_ff;
    assign analogZeroOffset = anaZero_ff;
    assign analogSpeedLpfBw = anaLpf_ff;

    // ------------------------------------------------------------------
    // Gear selection and pulse scaling
    // ------------------------------------------------------------------
    // Ratio follows the pin directly; controller keeps pulses away from its edges
    wire useSecond = dynGear_ff & gearSel;  // R1 R2 R3 R14
    wire [15:0] selNumer = useSecond ? gearSecond_ff : gearFirst_ff;  // R2
    // Pin is inhibit only while dynamic gear is off
    wire inhibitOn = ~dynGear_ff & ~inhIgnore_ff & gearSel;  // R14
    wire posMode = (activeMode == svc_pkg::MODE_POSITION);
    wire pulseTaken = pulseRise & posMode & motorEnable & ~inhibitOn;

    svc_gear_scaler u_scaler (
        .clk(clk),
        .rst(rst),
        .inPulse(pulseTaken),
        .numer(selNumer),
        .denom(gearShared_ff),
        .outPulse(gearPulse),
        .busy()
    );

    // Position within one revolution and whole revolutions
    logic [13:0] posCount_ff;
    logic [15:0] revCount_ff;
    wire posWrap = (posCount_ff == svc_pkg::REV_COUNTS - 14'h0001);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            posCount_ff <= 14'h0000;
            revCount_ff <= 16'h0000;
        end else if (gearPulse) begin
            posCount_ff <= posWrap ? 14'h0000 : posCount_ff + 14'h0001;  // R15
            revCount_ff <= posWrap ? revCount_ff + 16'h0001 : revCount_ff;
        end
    end

    // ------------------------------------------------------------------
    // Control mode
    // ------------------------------------------------------------------
    function automatic svc_pkg::svc_mode_e baseMode(input logic [3:0] sel, input logic adv);
        unique case (sel)  // R9 R10
            svc_pkg::BASE_SPEED: baseMode = adv ? svc_pkg::MODE_TORQUE : svc_pkg::MODE_SPEED;
            svc_pkg::BASE_TORQUE: baseMode = adv ? svc_pkg::MODE_POSITION : svc_pkg::MODE_TORQUE;
            default: baseMode = adv ? svc_pkg::MODE_SPEED : svc_pkg::MODE_POSITION;
        endcase
    endfunction
    // Pin advances the mode only when switching is allowed
    wire switchOn = switchAllow_ff & altSw;  // R7 R8
    svc_pkg::svc_mode_e modeNow;
    assign modeNow = baseMode(modeSel_ff, switchOn);  // R7 R10
    assign activeMode = modeNow;
    assign speedFromAnalog = (speedSrc_ff != 2'h0);  // R11

    logic [1:0] modePrev_ff;  // For change events
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            modePrev_ff <= svc_pkg::MODE_POSITION;
        end else begin
            modePrev_ff <= activeMode;
        end
    end

    // ------------------------------------------------------------------
    // Run direction from limit inputs
    // ------------------------------------------------------------------
    wire dirCcw = ccwOn & ~cwOn;
    wire dirCw = cwOn & ~ccwOn;
    assign runDir = (dirCcw ^ dirInvert_ff) & (dirCcw | dirCw) ? svc_pkg::DIR_CCW :  // R5 R6
                    (dirCcw | dirCw) ? svc_pkg::DIR_CW : svc_pkg::DIR_STOP;

    // ------------------------------------------------------------------
    // User torque overload
    // ------------------------------------------------------------------
    logic [31:0] tickCnt_ff;   // Millisecond divider
    logic [15:0] ovlMs_ff;     // Milliseconds spent over level
    logic alarm_ff;
    wire tick = (tickCnt_ff == 32'(MS_CYCLES - 1));
    wire ovlActive = (ovlCfg_ff[31:16] != 16'h0000);  // R13
    wire overLevel = ovlActive & (motorTorque > ovlCfg_ff[15:0]);  // R13
    wire ovlTrip = overLevel & (ovlMs_ff >= ovlCfg_ff[31:16]);  // R12
    // Pin release only while it is not the mode switch
    wire alarmRelease = swRelease | (altRise & ~switchAllow_ff);  // R7 R8

    // Divider and over-level timer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tickCnt_ff <= 32'h0000_0000;
            ovlMs_ff <= 16'h0000;
        end else begin
            tickCnt_ff <= tick ? 32'h0000_0000 : tickCnt_ff + 32'h0000_0001;
            if (!overLevel) begin
                ovlMs_ff <= 16'h0000;
            end else if (tick && ovlMs_ff != 16'hffff) begin
                ovlMs_ff <= ovlMs_ff + 16'h0001;
            end
        end
    end

    // Alarm latches; a new trip wins over a release
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            alarm_ff <= 1'b0;
        end else if (ovlTrip) begin
            alarm_ff <= 1'b1;  // R12
        end else if (alarmRelease) begin
            alarm_ff <= 1'b0;
        end
    end
    assign overloadAlarm = alarm_ff;
    assign motorEnable = servoOn & ~alarm_ff;  // R12

    // ------------------------------------------------------------------
    // Interrupts and read-back
    // ------------------------------------------------------------------
    // Ratio-change event only on a pin edge, never while the ratio just stays put
    wire [IRQ_W_L-1:0] events = {(useSecond ^ (dynGear_ff & pinPrev_ff[1])) & gearEdge,
                                 (activeMode != modePrev_ff), ovlTrip & ~alarm_ff};
    wire [IRQ_W_L-1:0] clrMask = wrStat ? pwdata[IRQ_W_L-1:0] : '0;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irqStat_ff <= '0;
        end else begin
            irqStat_ff <= (irqStat_ff & ~clrMask) | events;  // Set wins
        end
    end
    assign irq = |(irqStat_ff & irqMask_ff);

    wire [31:0] cfgWord = {20'h00000, inhIgnore_ff, dirInvert_ff, dynGear_ff, switchAllow_ff,
                           2'h0, speedSrc_ff, modeSel_ff};
    wire [31:0] statWord = {25'h0000000, useSecond, speedFromAnalog, alarm_ff, runDir, activeMode};
    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h0000_0000;
        for (int k = 0; k < 6; k++) begin
            if (hit(paddr, WORD_OFS[k])) rdMux = {16'h0000, wordReg_ff[k]};
        end
        if (hit(paddr, svc_pkg::OFS_MODE_CFG)) rdMux = cfgWord;
        if (hit(paddr, svc_pkg::OFS_OVL_CFG)) rdMux = ovlCfg_ff;
        if (hit(paddr, svc_pkg::OFS_STATUS)) rdMux = statWord;
        if (hit(paddr, svc_pkg::OFS_POSITION)) rdMux = {revCount_ff, 2'h0, posCount_ff};
        if (hit(paddr, svc_pkg::OFS_IRQ_STAT)) rdMux = {29'h00000000, irqStat_ff};
        if (hit(paddr, svc_pkg::OFS_IRQ_MASK)) rdMux = {29'h00000000, irqMask_ff};
    end
    // Read data registered in the setup cycle, valid in the access cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (rdEn && !penable) begin
            prdata <= rdMux;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_gear_off_first: assert property (!dynGear_ff |-> selNumer == gearFirst_ff) // R1
        else $error("Second ratio used with dynamic gear off");
    a_gear_on_second: assert property (dynGear_ff && gearSel |-> selNumer == gearSecond_ff) // R2
        else $error("Second ratio not selected");
    a_inhibit_repurpose: assert property (dynGear_ff && gearSel && pulseRise && posMode
        && motorEnable |-> pulseTaken) // R14
        else $error("Gear pin still inhibits pulses");
    a_dir_equal_stop: assert property (ccwOn == cwOn |-> runDir == svc_pkg::DIR_STOP) // R5
        else $error("Equal limits did not stop");
    a_dir_invert_swap: assert property (dirInvert_ff && ccwOn && !cwOn |-> runDir == svc_pkg::DIR_CW) // R6
        else $error("Invert did not swap direction");
    a_mode_fixed_base: assert property (!switchAllow_ff && modeSel_ff == svc_pkg::BASE_TORQUE
        |-> activeMode == svc_pkg::MODE_TORQUE) // R7
        else $error("Mode moved without switching allowed");
    a_mode_switch_pin: assert property (switchAllow_ff && modeSel_ff == svc_pkg::BASE_SPEED && altSw
        |-> activeMode == svc_pkg::MODE_TORQUE) // R10
        else $error("Switch pin did not advance mode");
    a_no_pin_release: assert property (switchAllow_ff && alarm_ff && !swRelease |=> alarm_ff) // R8
        else $error("Alarm cleared by mode-switch pin");
    a_speed_source: assert property (speedSrc_ff == 2'h0 |-> !speedFromAnalog) // R11
        else $error("Internal speed source not taken");
    a_ovl_disabled: assert property (ovlCfg_ff[31:16] == 16'h0000 && !alarm_ff |=> !alarm_ff) // R13
        else $error("Overload alarm with check disabled");
    a_alarm_stops: assert property (ovlTrip |=> alarm_ff && !motorEnable) // R12
        else $error("Overload trip did not stop motor");
    a_pos_wrap: assert property (gearPulse && posWrap |=> posCount_ff == 14'h0000) // R15
        else $error("Revolution wrap wrong");

endmodule : svc_mode_select

`default_nettype wire

// [rtl/svc_pkg.sv]
// Shared constants and types for the servo command-mode select block
`default_nettype none

package svc_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;       // 10 MHz system clock
    localparam int OVL_TICK_NS = 1000000;     // Overload timer unit, 1 ms
    localparam int OVL_TICK_CYCLES = OVL_TICK_NS / CLK_PERIOD_NS;  // Cycles per overload timer tick, rounds down
    localparam int GEAR_GUARD_MS = 10;        // Pulse-free window around a gear change

    // ------------------------------------------------------------------
    // Feedback scale
    // ------------------------------------------------------------------
    localparam logic [13:0] REV_COUNTS = 14'h2710;  // 10000 counts per revolution after x4 decode

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_MODE_CFG = 8'h00;
    localparam logic [7:0] OFS_GEAR_FIRST = 8'h04;
    localparam logic [7:0] OFS_GEAR_SECOND = 8'h08;
    localparam logic [7:0] OFS_GEAR_SHARED = 8'h0c;
    localparam logic [7:0] OFS_ANA_GAIN = 8'h10;
    localparam logic [7:0] OFS_ANA_ZERO = 8'h14;
    localparam logic [7:0] OFS_ANA_LPF = 8'h18;
    localparam logic [7:0] OFS_OVL_CFG = 8'h1c;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_POSITION = 8'h24;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h28;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h2c;
    localparam logic [7:0] OFS_COMMAND = 8'h30;

    // ------------------------------------------------------------------
    // Mode configuration fields
    // ------------------------------------------------------------------
    localparam int CFG_MODE_LSB = 0;          // control_mode_select [3:0]
    localparam int CFG_SRC_LSB = 4;           // speed_source_select [5:4]
    localparam int CFG_SWITCH_BIT = 8;        // mode_switch_allow
    localparam int CFG_DYNGEAR_BIT = 9;       // dyn_gear_enable
    localparam int CFG_INVERT_BIT = 10;       // analog_dir_invert
    localparam int CFG_INHIGN_BIT = 11;       // inhibit_ignore
    localparam int CMD_RELEASE_BIT = 0;       // Software alarm release

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [3:0] RST_MODE_SEL = 4'h0;
    localparam logic [1:0] RST_SPEED_SRC = 2'h1;
    localparam logic [15:0] RST_GEAR_TERM = 16'h0001;
    localparam logic [15:0] RST_ANA_GAIN = 16'h012c;  // 300
    localparam logic [15:0] RST_ANA_ZERO = 16'h0000;
    localparam logic [15:0] RST_ANA_LPF = 16'h012c;   // 300
    localparam logic [31:0] RST_OVL_CFG = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Base mode codes of control_mode_select
    // ------------------------------------------------------------------
    localparam logic [3:0] BASE_POSITION = 4'h0;
    localparam logic [3:0] BASE_SPEED = 4'h1;
    localparam logic [3:0] BASE_TORQUE = 4'h6;

    // ------------------------------------------------------------------
    // Interrupt status bits
    // ------------------------------------------------------------------
    localparam int IRQ_ALARM = 0;
    localparam int IRQ_MODE = 1;
    localparam int IRQ_GEAR = 2;
    localparam int IRQ_W = 3;

    // Active control mode
    typedef enum logic [1:0] {MODE_POSITION, MODE_SPEED, MODE_TORQUE} svc_mode_e;

    // Decoded run direction
    typedef enum logic [1:0] {DIR_STOP, DIR_CCW, DIR_CW} svc_dir_e;

endpackage : svc_pkg

`default_nettype wire

// [tb/svc_ctrl_model.sv]
// Motion controller model: gear select and command pulses
`default_nettype none
module svc_ctrl_model (
    input wire logic clk,
    output logic cmdPulsePin,
    output logic gearSelectPin
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int MS_TB = 10;  // Cycles per bench millisecond, as the design's divider is set
    initial cmdPulsePin = 1'b0;
    initial gearSelectPin = 1'b0;
    // Gear change inside a pulse-free spell of the guard time either side, then n pulses
    task automatic burst(input logic g, input int n);
        repeat (svc_pkg::GEAR_GUARD_MS * MS_TB) @(posedge clk);
        gearSelectPin <= g;
        repeat (svc_pkg::GEAR_GUARD_MS * MS_TB) @(posedge clk);
        repeat (n) begin
            cmdPulsePin <= 1'b1;
            repeat (2) @(posedge clk);
            cmdPulsePin <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask
endmodule // svc_ctrl_model
`default_nettype wire

// [tb/svc_mode_select_tb_top.sv]
// Self-checking bench for the command-mode select block
`default_nettype none
module svc_mode_select_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ccwLimitPin = 1'b0;
    logic cwLimitPin = 1'b0, alarmClearPin = 1'b0, servoOnPin = 1'b0, pready, pslverr, err;
    logic cmdPulsePin, gearSelectPin, gearPulse, speedFromAnalog, motorEnable, overloadAlarm, irq;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [15:0] motorTorque = 16'h0000;
    logic [15:0] aGain, aZero, aLpf;
    logic [1:0] activeMode, runDir;
    int n_mismatch = 0, comparisons = 0, cyc = 0, gpCnt = 0;
    initial forever #50 clk = ~clk;
    svc_ctrl_model u_svc_ctrl_model (.clk, .cmdPulsePin, .gearSelectPin);
    svc_mode_select #(.MS_CYCLES(10)) u_svc_mode_select (.clk, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .cmdPulsePin, .gearSelectPin, .ccwLimitPin, .cwLimitPin,
        .alarmClearPin, .servoOnPin, .motorTorque, .gearPulse, .activeMode, .runDir, .speedFromAnalog,
        .motorEnable, .overloadAlarm, .analogSpeedGain(aGain), .analogZeroOffset(aZero),
        .analogSpeedLpfBw(aLpf), .irq);
    // Hang limit and count of geared output pulses
    always @(posedge clk) begin
        cyc <= cyc + 1;
        gpCnt <= gpCnt + int'(gearPulse === 1'b1);
        if (cyc == 5000) begin
            n_mismatch++;
            close_out();
        end
    end
    task automatic close_out();
        if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask
    // One transfer; waits for pready rather than assuming zero wait
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(r, e);
    endtask
    task automatic t_reset();
        rdchk(8'h10, 32'h12c);
        rdchk(8'h18, 32'h12c);
        rdchk(8'h00, 32'h10);
        chk({aGain, aZero}, 32'h012c_0000);
        chk(32'(aLpf), 32'h12c);
        rdchk(8'h34, 32'h0);
        chk(32'(err), 32'h1);
    endtask
    task automatic t_dir();
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, 8'h00, {21'h0, i[2], 10'h10});
            ccwLimitPin <= i[1];
            cwLimitPin <= i[0];
            repeat (4) @(posedge clk);
            chk(32'(runDir), (i[1] == i[0]) ? 32'h0 : ((i[1] ^ i[2]) ? 32'h1 : 32'h2));
        end
    endtask
    task automatic t_mode();
        logic [1:0] m;
        for (int i = 0; i < 12; i++) begin
            m = 2'(i / 4);
            apb(1'b1, 8'h00, {23'h0, i[1], 3'h0, i[1] ^ i[0], (m == 2'h2) ? 4'h6 : 4'(m)});
            alarmClearPin <= i[0];
            repeat (4) @(posedge clk);
            if (i[1] && i[0]) m = (m == 2'h2) ? 2'h0 : m + 2'h1;
            chk(32'(activeMode), 32'(m));
            chk(32'(speedFromAnalog), 32'(i[1] ^ i[0]));
        end
    endtask
    task automatic t_gear();
        int c0;
        apb(1'b1, 8'h00, 32'h210);
        apb(1'b1, 8'h08, 32'h3);
        apb(1'b1, 8'h0c, 32'h2);
        for (int k = 1; k >= 0; k--) begin
            c0 = gpCnt;
            u_svc_ctrl_model.burst(k[0], 4);
            repeat (20) @(posedge clk);
            chk(gpCnt - c0, k ? 32'h6 : 32'h2);
        end
        rdchk(8'h24, 32'h8);
    endtask
    task automatic t_ovl();
        alarmClearPin <= 1'b0;
        apb(1'b1, 8'h2c, 32'h1);
        apb(1'b1, 8'h1c, 32'h64);
        motorTorque <= 16'h00c8;
        repeat (50) @(posedge clk);
        chk(32'(overloadAlarm), 32'h0);
        apb(1'b1, 8'h1c, 32'h2_0064);
        repeat (40) @(posedge clk);
        chk({29'h0, irq, overloadAlarm, motorEnable}, 32'h6);
        motorTorque <= 16'h0000;
        apb(1'b1, 8'h00, 32'h110);
        alarmClearPin <= 1'b1;
        repeat (4) @(posedge clk);
        chk(32'(overloadAlarm), 32'h1);
        apb(1'b1, 8'h00, 32'h10);
        alarmClearPin <= 1'b0;
        repeat (4) @(posedge clk);
        alarmClearPin <= 1'b1;
        apb(1'b1, 8'h28, 32'h1);
        repeat (4) @(posedge clk);
        chk({29'h0, irq, overloadAlarm, motorEnable}, 32'h1);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        servoOnPin <= 1'b1;
        t_reset();
        t_dir();
        t_mode();
        t_gear();
        t_ovl();
        close_out();
    end
endmodule // svc_mode_select_tb_top
`default_nettype wire
